// ===== vga_regs.sv
// video gate array register front end on the host i/o and memory bus
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - writing the index port selects which array register data writes update
// - reading the index port returns four status bits, bits 4-7 zero
// - any access to the clear port clears the pen latch while the synchronised pen trigger is low
// - any access to the preset port sets the pen latch
// - array register 01 holds a four-bit palette mask gating colour index
// - array register 02 holds border colour blue, green, red, intensity
// - array register 03 holds border enable, four-colour hi-res, sixteen-colour
// - array registers 10 to 1F are sixteen four-bit palette entries
// - mode register bits 0-2: hi-res clock, graphics, black-and-white
// - mode register bits 3-5: video enable, 640-dot graphics, blink
// - colour register bits 0-3 give background colour
// - colour register bit 4 foreground intensity, bit 5 colour set
// - page register holds display page bits 0-2, processor page 3-5
// - page register bits 6-7 give the video address mode
// - host memory accesses reach video only through the fixed window
module vga_regs
  import vga_pkg::*;
#(
  parameter int NUM_PAL = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ioWr,
  input wire logic ioRd,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  output logic ioRdHit,
  input wire logic memReq,
  input wire logic [19:0] memAddr,
  output logic memHit,
  output logic [16:0] memOffset,
  output logic [2:0] cpuPage,
  input wire logic displayInactive,
  input wire logic vertRetrace,
  input wire logic penTrigger,
  input wire logic penSwitch,
  input wire logic [3:0] pixelIndex,
  output logic [3:0] paletteColour,
  output vga_mode_s modeOut,
  output vga_colour_s colourOut,
  output vga_ext_s extOut,
  output vga_page_s pageOut,
  output logic [3:0] borderColour
);
  function automatic logic isPort(input logic [15:0] a, input logic [15:0] p);
    return a == p;
  endfunction

  function automatic logic isIdx(input logic [4:0] a, input logic [4:0] p);
    return a == p;
  endfunction

  vga_mode_s mode_r;
  vga_colour_s colour_r;
  vga_ext_s ext_r;
  vga_page_s page_r;
  logic [4:0] index_r;
  logic [3:0] palMask_r;
  logic [3:0] border_r;
  logic [3:0] pal_r [NUM_PAL];
  logic penLatch_r;
  logic [7:0] rdData_r;
  logic inSync1_r;
  logic inSync2_r;
  logic reSync1_r;
  logic reSync2_r;
  logic pnSync1_r;
  logic pnSync2_r;
  logic swSync1_r;
  logic swSync2_r;
  vga_mode_s mode_nxt;
  vga_colour_s colour_nxt;
  vga_ext_s ext_nxt;
  vga_page_s page_nxt;
  logic [4:0] index_nxt;
  logic [3:0] palMask_nxt;
  logic [3:0] border_nxt;
  logic penLatch_nxt;
  logic [7:0] rdData_nxt;
  logic [3:0] palColour_nxt;
  logic [3:0] palColour_r;

  // i/o port decode
  wire logic anyAcc = ioWr | ioRd;
  wire logic wrMode = ioWr & isPort(ioAddr, ADDR_MODE);
  wire logic wrColour = ioWr & isPort(ioAddr, ADDR_COLOUR);
  wire logic wrIndex = ioWr & isPort(ioAddr, ADDR_INDEX);
  wire logic wrData = ioWr & isPort(ioAddr, ADDR_DATA);
  wire logic wrPage = ioWr & isPort(ioAddr, ADDR_PAGE);
  wire logic penClr = anyAcc & isPort(ioAddr, ADDR_PEN_CLR);
  wire logic penSet = anyAcc & isPort(ioAddr, ADDR_PEN_SET);
  wire logic rdMode = isPort(ioAddr, ADDR_MODE);
  wire logic rdColour = isPort(ioAddr, ADDR_COLOUR);
  wire logic rdStatus = isPort(ioAddr, ADDR_INDEX);
  wire logic rdPage = isPort(ioAddr, ADDR_PAGE);
  wire logic rdHit = ioRd & (rdMode | rdColour | rdStatus | rdPage);
  wire logic palSel = index_r[4];
  wire logic [3:0] palIdx = index_r[3:0];
  // data writes use the loaded index
  wire logic wrMask = wrData & isIdx(index_r, IDX_MASK);
  wire logic wrBorder = wrData & isIdx(index_r, IDX_BORDER);
  wire logic wrExt = wrData & isIdx(index_r, IDX_EXT);
  wire logic [3:0] maskedIdx = pixelIndex & palMask_r;
  logic [7:0] statusByte;
  logic [7:0] rdMux;

  always_comb begin
    statusByte = RESET_BYTE;
    statusByte[ST_INACTIVE] = inSync2_r;
    statusByte[ST_PEN_SET] = penLatch_r;
    statusByte[ST_PEN_SW] = swSync2_r;
    statusByte[ST_VRETRACE] = reSync2_r;
  end

  always_comb begin
    rdMux = RESET_BYTE;
    if (rdMode) begin
      rdMux = {2'b00, mode_r};
    end else if (rdColour) begin
      rdMux = {2'b00, colour_r};
    end else if (rdStatus) begin
      rdMux = statusByte;
    end else if (rdPage) begin
      rdMux = page_r;
    end
  end

  // pin inputs through two flops
  always_ff @(posedge clk) begin
    if (rst) begin
      inSync1_r <= 1'b0;
      inSync2_r <= 1'b0;
      reSync1_r <= 1'b0;
      reSync2_r <= 1'b0;
      pnSync1_r <= 1'b0;
      pnSync2_r <= 1'b0;
      swSync1_r <= 1'b0;
      swSync2_r <= 1'b0;
    end else begin
      inSync1_r <= displayInactive;
      inSync2_r <= inSync1_r;
      reSync1_r <= vertRetrace;
      reSync2_r <= reSync1_r;
      pnSync1_r <= penTrigger;
      pnSync2_r <= pnSync1_r;
      swSync1_r <= penSwitch;
      swSync2_r <= swSync1_r;
    end
  end

  assign mode_nxt = wrMode ? vga_mode_s'(ioWrData[5:0]) : mode_r;
  assign colour_nxt = wrColour ? vga_colour_s'(ioWrData[5:0]) : colour_r;
  assign index_nxt = wrIndex ? ioWrData[4:0] : index_r;
  assign page_nxt = wrPage ? vga_page_s'(ioWrData) : page_r;

  assign palMask_nxt = wrMask ? ioWrData[3:0] : palMask_r;
  assign border_nxt = wrBorder ? ioWrData[3:0] : border_r;
  assign ext_nxt = wrExt ? vga_ext_s'(ioWrData[4:2]) : ext_r;

  assign penLatch_nxt = penSet | pnSync2_r | (penLatch_r & ~penClr);
  // read data held until the next hit
  assign rdData_nxt = rdHit ? rdMux : rdData_r;
  assign palColour_nxt = pal_r[maskedIdx];

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_r <= '0;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      colour_r <= '0;
    end else begin
      colour_r <= colour_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      index_r <= '0;
    end else begin
      index_r <= index_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      page_r <= '0;
    end else begin
      page_r <= page_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      palMask_r <= '0;
    end else begin
      palMask_r <= palMask_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      border_r <= '0;
    end else begin
      border_r <= border_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ext_r <= '0;
    end else begin
      ext_r <= ext_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      penLatch_r <= 1'b0;
    end else begin
      penLatch_r <= penLatch_nxt;
    end
  end

  // read data register
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData_r <= RESET_BYTE;
    end else begin
      rdData_r <= rdData_nxt;
    end
  end

  // registered palette lookup
  always_ff @(posedge clk) begin
    if (rst) begin
      palColour_r <= '0;
    end else begin
      palColour_r <= palColour_nxt;
    end
  end

  generate
    for (genvar g = 0; g < NUM_PAL; g++) begin : g_pal
      wire logic palHit = wrData && palSel && palIdx == 4'(g);
      always_ff @(posedge clk) begin
        if (rst) begin
          pal_r[g] <= '0;
        end else if (palHit) begin
          pal_r[g] <= ioWrData[3:0];
        end
      end
    end
  endgenerate

  assign ioRdData = rdData_r;
  assign ioRdHit = rdHit;

  // fixed host window, page chosen by bit 0 of the processor page field
  assign memHit = memReq && memAddr >= WINDOW_BASE && memAddr <= WINDOW_END;
  assign memOffset = {page_r.cpuPage[0], memAddr[15:0]};
  assign cpuPage = page_r.cpuPage;

  assign paletteColour = palColour_r;
  assign modeOut = mode_r;
  assign colourOut = colour_r;
  assign extOut = ext_r;
  assign pageOut = page_r;
  assign borderColour = border_r;
endmodule
`default_nettype wire

// ===== vga_pkg.sv
// package for the video gate array register front end
package vga_pkg;
  localparam logic [15:0] ADDR_MODE = 16'h03D8;
  localparam logic [15:0] ADDR_COLOUR = 16'h03D9;
  localparam logic [15:0] ADDR_INDEX = 16'h03DA;
  localparam logic [15:0] ADDR_PEN_CLR = 16'h03DB;
  localparam logic [15:0] ADDR_PEN_SET = 16'h03DC;
  localparam logic [15:0] ADDR_DATA = 16'h03DE;
  localparam logic [15:0] ADDR_PAGE = 16'h03DF;
  localparam logic [4:0] IDX_MASK = 5'h01;
  localparam logic [4:0] IDX_BORDER = 5'h02;
  localparam logic [4:0] IDX_EXT = 5'h03;
  localparam logic [4:0] IDX_PAL_BASE = 5'h10;
  localparam int ST_INACTIVE = 0;
  localparam int ST_PEN_SET = 1;
  localparam int ST_PEN_SW = 2;
  localparam int ST_VRETRACE = 3;
  localparam int PG_DISP_LSB = 0;
  localparam int PG_CPU_LSB = 3;
  localparam int PG_MODE_LSB = 6;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [19:0] WINDOW_BASE = 20'hB8000;
  localparam logic [19:0] WINDOW_END = 20'hBFFFF;

  typedef struct packed {
    logic blink;
    logic dots640;
    logic videoEn;
    logic mono;
    logic graphics;
    logic hiResClk;
  } vga_mode_s;

  typedef struct packed {
    logic colourSet;
    logic fgIntens;
    logic [3:0] background;
  } vga_colour_s;

  typedef struct packed {
    logic sixteenColour;
    logic fourColourHi;
    logic borderEn;
  } vga_ext_s;

  typedef struct packed {
    logic [1:0] addrMode;
    logic [2:0] cpuPage;
    logic [2:0] dispPage;
  } vga_page_s;
endpackage

// ===== vga_regs_asserts.sv
// port assertions for the register front end
`timescale 1ns/100ps
`default_nettype none
module vga_regs_chk
  import vga_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ioWr,
  input wire logic ioRd,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData,
  input wire logic ioRdHit,
  input wire logic memReq,
  input wire logic [19:0] memAddr,
  input wire logic memHit,
  input wire vga_mode_s modeOut,
  input wire vga_page_s pageOut,
  input wire logic [3:0] borderColour
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_mode; ioWr && ioAddr == ADDR_MODE |=> modeOut == $past(ioWrData[5:0]); endproperty
  a_mode: assert property (p_mode) else $error("mode lost");
  property p_page; ioWr && ioAddr == ADDR_PAGE |=> pageOut == $past(ioWrData); endproperty
  a_page: assert property (p_page) else $error("page lost");
  property p_hit; ioRdHit == (ioRd && (ioAddr == ADDR_MODE || ioAddr == ADDR_COLOUR
    || ioAddr == ADDR_INDEX || ioAddr == ADDR_PAGE)); endproperty
  a_hit: assert property (p_hit) else $error("bad read decode");
  property p_mem; memHit == (memReq && memAddr >= WINDOW_BASE && memAddr <= WINDOW_END); endproperty
  a_mem: assert property (p_mem) else $error("bad window");
  property p_rst; disable iff (1'b0) rst |=> modeOut == 6'h00 && pageOut == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("not cleared");
  property p_stat; ioRd && ioAddr == ADDR_INDEX |=> ioRdData[7:4] == 4'h0; endproperty
  a_stat: assert property (p_stat) else $error("status high bits");
  property p_idx; ioWr && ioAddr == ADDR_INDEX && ioWrData == 8'h02 ##1 ioWr && ioAddr == ADDR_DATA
    |=> borderColour == $past(ioWrData[3:0]); endproperty
  a_idx: assert property (p_idx) else $error("border lost");
  property p_pen; ioWr && ioAddr == ADDR_PEN_SET ##1 ioRd && ioAddr == ADDR_INDEX
    |=> ioRdData[ST_PEN_SET]; endproperty
  a_pen: assert property (p_pen) else $error("preset lost");
endmodule
bind vga_regs vga_regs_chk vga_regs_chk_inst (.clk, .rst, .ioWr, .ioRd, .ioAddr, .ioWrData,
  .ioRdData, .ioRdHit, .memReq, .memAddr, .memHit, .modeOut, .pageOut, .borderColour);
`default_nettype wire

// ===== vga_host.sv
// host processor model on the i/o port bus
`timescale 1ns/100ps
`default_nettype none
module vga_host
  import vga_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] ioRdData,
  output logic ioWr,
  output logic ioRd,
  output logic [15:0] ioAddr,
  output logic [7:0] ioWrData
);
  initial begin
    ioWr = 1'b0;
    ioRd = 1'b0;
    ioAddr = 16'h0000;
    ioWrData = 8'h00;
  end
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    ioWr = 1'b1;
    ioRd = 1'b0;
    ioAddr = a;
    ioWrData = d;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    ioWr = 1'b0;
    ioRd = 1'b1;
    ioAddr = a;
    @(posedge clk);
    #1;
    d = ioRdData;
  endtask
  // released bus shows inverted values
  task automatic idle;
    ioWr = 1'b0;
    ioRd = 1'b0;
    ioAddr = ~ioAddr;
    ioWrData = ~ioWrData;
    @(posedge clk);
    #1;
  endtask
  task automatic setArr(input logic [4:0] i, input logic [7:0] v);
    wr(ADDR_INDEX, {3'h0, i});
    wr(ADDR_DATA, v);
    idle();
  endtask
endmodule
`default_nettype wire

// ===== vga_regs_bench.sv
// self-checking bench for the register front end
`timescale 1ns/100ps
`default_nettype none
module vga_regs_bench
  import vga_pkg::*;
;
  logic clk, rst, ioWr, ioRd, ioRdHit, memReq, memHit, dIn, vRet, penSw, penTr;
  logic [15:0] ioAddr;
  logic [7:0] ioWrData, ioRdData, d, r, p;
  logic [16:0] memOffset;
  logic [2:0] cpuPage;
  logic [19:0] memAddr;
  logic [3:0] pixelIndex, paletteColour, borderColour;
  logic [3:0] pal [16];
  vga_mode_s modeOut;
  vga_colour_s colourOut;
  vga_ext_s extOut;
  vga_page_s pageOut;
  int mismatches, checks, seed, i;
  vga_regs vga_regs_inst (.clk, .rst, .ioWr, .ioRd, .ioAddr, .ioWrData, .ioRdData, .ioRdHit,
    .memReq, .memAddr, .memHit, .memOffset, .cpuPage, .displayInactive(dIn),
    .vertRetrace(vRet), .penTrigger(penTr), .penSwitch(penSw), .pixelIndex, .paletteColour,
    .modeOut, .colourOut, .extOut, .pageOut, .borderColour);
  vga_host vga_host_inst (.clk, .ioRdData, .ioWr, .ioRd, .ioAddr, .ioWrData);
  function automatic logic [7:0] stat(input logic i0, l, s, v);
    return {4'h0, v, s, l, i0};
  endfunction
  task automatic cmp(input logic [19:0] g, input logic [19:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #50000;
    mismatches++;
    end_of_test();
  end
  initial begin
    seed = 21586;
    {rst, memReq, memAddr, dIn, vRet, penSw, penTr, pixelIndex} = {1'b1, 29'h0};
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    cmp({2'h0, modeOut}, 8'h00);
    for (i = 0; i < 6; i++) begin
      r = 8'($random(seed));
      vga_host_inst.wr(ADDR_MODE, r);
      vga_host_inst.wr(ADDR_COLOUR, ~r);
      p = r + 8'h5A;
      vga_host_inst.wr(ADDR_PAGE, p);
      vga_host_inst.rd(ADDR_PAGE, d);
      cmp({2'h0, modeOut}, {2'h0, r[5:0]});
      cmp({2'h0, colourOut}, {2'h0, ~r[5:0]});
      cmp(d, p);
      cmp(pageOut, p);
      cmp({5'h00, cpuPage}, {5'h00, p[5:3]});
      vga_host_inst.setArr(IDX_BORDER, r);
      vga_host_inst.setArr(IDX_EXT, ~r);
      cmp({4'h0, borderColour}, {4'h0, r[3:0]});
      cmp({5'h00, extOut}, {5'h00, ~r[4:2]});
    end
    vga_host_inst.setArr(IDX_MASK, 8'h0F);
    for (i = 0; i < 16; i++) begin
      pal[i] = 4'($random(seed));
      vga_host_inst.setArr(IDX_PAL_BASE + 5'(i), {4'h0, pal[i]});
    end
    for (i = 0; i < 32; i++) begin
      if (i == 16) vga_host_inst.setArr(IDX_MASK, 8'h03);
      pixelIndex = 4'(i);
      @(posedge clk);
      #1;
      cmp({4'h0, paletteColour}, {4'h0, pal[4'(i) & (i < 16 ? 4'hF : 4'h3)]});
    end
    for (i = 0; i < 6; i++) begin
      {dIn, vRet, penSw} = 3'($random(seed));
      vga_host_inst.wr(i[0] ? ADDR_PEN_CLR : ADDR_PEN_SET, 8'($random(seed)));
      repeat (3) vga_host_inst.idle();
      vga_host_inst.rd(ADDR_INDEX, d);
      cmp(d, stat(dIn, !i[0], penSw, vRet));
    end
    vga_host_inst.wr(ADDR_PEN_SET, 8'h00);
    vga_host_inst.rd(ADDR_INDEX, d);
    cmp(d, stat(dIn, 1'b1, penSw, vRet));
    vga_host_inst.rd(ADDR_PEN_CLR, d);
    vga_host_inst.rd(ADDR_INDEX, d);
    cmp(d, stat(dIn, 1'b0, penSw, vRet));
    penTr = 1'b1;
    repeat (3) vga_host_inst.idle();
    penTr = 1'b0;
    repeat (3) vga_host_inst.idle();
    vga_host_inst.rd(ADDR_INDEX, d);
    cmp(d, stat(dIn, 1'b1, penSw, vRet));
    memReq = 1'b1;
    for (i = 0; i < 4; i++) begin
      memAddr = i[1] ? (i[0] ? 20'hC0000 : 20'hBFFFF) : (i[0] ? 20'hB8000 : 20'hB7FFF);
      @(posedge clk);
      #1;
      cmp({7'h00, memHit}, {7'h00, i[0] ^ i[1]});
      cmp(memOffset, {p[3], memAddr[15:0]});
    end
    rst = 1'b1;
    @(posedge clk);
    #1;
    rst = 1'b0;
    cmp({2'h0, modeOut}, 8'h00);
    cmp({2'h0, colourOut}, 8'h00);
    cmp(pageOut, 8'h00);
    cmp({5'h00, extOut}, 8'h00);
    cmp({4'h0, borderColour}, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
